// >>> testbench/pmsr_line_model.sv
// Line-condition model standing in for the far side of the block
`timescale 1ns/100ps
module pmsr_line_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Requested conditions
  input wire pmsr_pkg::pmsr_phy_line_t line_cmd,
  input wire logic strap_cmd,
  // Toward the block
  output pmsr_pkg::pmsr_phy_line_t phy_line,
  output logic ten_mbps_only_strap
);
  // Registered so levels move clear of the sampling edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phy_line <= '0;
      ten_mbps_only_strap <= 1'b0;
    end else begin
      phy_line <= line_cmd;
      ten_mbps_only_strap <= strap_cmd;
    end
  end
endmodule // pmsr_line_model

// >>> testbench/testbench.sv
// Self-checking bench for the management register subset
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic [31:0] d;
    logic e;
    logic rd;
  } pmsr_exp_t;
  localparam logic [15:0] ID_U = 16'h1e2d; // Arbitrary value
  localparam logic [15:0] ID_L = 16'h4b3c; // Arbitrary value
  localparam logic [7:0] A_ST = {pmsr_pkg::IDX_BASIC_STATUS, 2'b00};
  localparam logic [7:0] A_IU = {pmsr_pkg::IDX_IDENTIFIER_UPPER, 2'b00};
  localparam logic [7:0] A_IL = {pmsr_pkg::IDX_IDENTIFIER_LOWER, 2'b00};
  localparam logic [7:0] A_AD = {pmsr_pkg::IDX_NEGOTIATION_ADVERTISEMENT, 2'b00};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  pmsr_pkg::pmsr_apb_req_t apb_req = '0;
  pmsr_pkg::pmsr_apb_rsp_t apb_rsp;
  pmsr_pkg::pmsr_phy_line_t line_cmd = '0;
  pmsr_pkg::pmsr_phy_line_t phy_line;
  logic strap_cmd = 1'b0;
  logic ten_mbps_only_strap;
  logic [15:0] adv_page;
  pmsr_exp_t exp_q[$];
  pmsr_exp_t e;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  integer seed = 32'h7953;
  logic [31:0] r;
  logic [15:0] adv_e;

  always #4 clk = ~clk;

  pmsr_line_model far_end (.clk(clk), .rstn(rstn), .line_cmd(line_cmd),
    .strap_cmd(strap_cmd), .phy_line(phy_line), .ten_mbps_only_strap(ten_mbps_only_strap));

  pmsr_regs #(.IDENT_UPPER(ID_U), .IDENT_LOWER(ID_L)) DUT (.clk(clk), .rstn(rstn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .phy_line(phy_line),
    .ten_mbps_only_strap(ten_mbps_only_strap), .adv_page(adv_page));

  function automatic logic [31:0] st(input int s, an, rf, lk, jb);
    return {16'h0, 1'b0, {2{~s[0]}}, 2'b11, 4'h0, 1'b0, an[0], rf[0], 1'b1, lk[0], jb[0], 1'b1};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask

  task automatic print_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     input logic [31:0] rd, input logic er);
    exp_q.push_back('{d: rd, e: er, rd: ~w});
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    // No local limit: only the cycle ceiling ends a hung access
    do begin
      @(posedge clk);
    end while (apb_rsp.pready !== 1'b1);
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] want);
    apb(1'b0, a, 32'h0, want, 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask

  // Six cycles cover the model flop plus the two-flop synchroniser
  task automatic line(input int lk, jb, rf, an, tm, s);
    @(posedge clk);
    line_cmd <= '{link_up: lk[0], jabber: jb[0], remote_fault: rf[0], an_complete: an[0],
      at_10m: tm[0]};
    strap_cmd <= s[0];
    repeat (6) @(posedge clk);
  endtask

  task automatic done(input string n);
    $display("Test %s finished", n);
  endtask

  always @(posedge clk) begin
    if (rstn && apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1) begin
      e = exp_q.pop_front();
      if (e.rd) check(apb_rsp.prdata, e.d);
      check({31'h0, apb_rsp.pslverr}, {31'h0, e.e});
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    check({16'h0, adv_page}, 32'h000005e1);
    rstn <= 1'b1;
    rd(A_ST, st(0, 0, 0, 0, 0));
    rd(A_IU, {16'h0, ID_U});
    rd(A_IL, {16'h0, ID_L});
    rd(A_AD, 32'h000005e1);
    wr(A_IU, 32'h0000ffff);
    wr(A_IL, 32'h00000000);
    wr(A_ST, 32'h0000ffff);
    rd(A_IU, {16'h0, ID_U});
    rd(A_IL, {16'h0, ID_L});
    rd(A_ST, st(0, 0, 0, 0, 0));
    done("reset_and_ident");
    for (int i = 0; i < 5; i++) begin
      r = $random(seed);
      if (i == 0) r = 32'hffffffff;
      adv_e = {2'b00, r[13:5], 5'h01};
      wr(A_AD, r);
      @(posedge clk);
      check({16'h0, adv_page}, {16'h0, adv_e});
      rd(A_AD, {16'h0, adv_e});
    end
    done("advertisement");
    apb(1'b0, 8'h00, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 8'h05, 32'h0, 32'h0, 1'b1);
    apb(1'b1, 8'h40, ~r, 32'h0, 1'b1);
    rd(A_AD, {16'h0, adv_e});
    done("unmapped");
    line(1, 0, 0, 0, 0, 0);
    rd(A_ST, st(0, 0, 0, 0, 0));
    rd(A_ST, st(0, 0, 0, 1, 0));
    line(0, 0, 0, 0, 0, 0);
    line(1, 0, 0, 0, 0, 0);
    rd(A_ST, st(0, 0, 0, 0, 0));
    rd(A_ST, st(0, 0, 0, 1, 0));
    line(1, 1, 0, 0, 1, 0);
    line(1, 0, 0, 0, 1, 0);
    rd(A_ST, st(0, 0, 0, 1, 1));
    rd(A_ST, st(0, 0, 0, 1, 0));
    line(1, 1, 0, 0, 0, 0);
    line(1, 0, 0, 0, 0, 0);
    rd(A_ST, st(0, 0, 0, 1, 0));
    done("latches");
    line(1, 0, 1, 1, 0, 1);
    rd(A_ST, st(1, 1, 1, 1, 0));
    wr(A_ST, 32'h00000000);
    rd(A_ST, st(1, 1, 1, 1, 0));
    line(1, 0, 0, 0, 0, 0);
    rd(A_ST, st(0, 0, 0, 1, 0));
    done("strap_and_status");
    wr(A_AD, 32'h0000ffff);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    check({16'h0, adv_page}, 32'h000005e1);
    rstn <= 1'b1;
    rd(A_ST, st(0, 0, 0, 0, 0));
    rd(A_AD, 32'h000005e1);
    done("midrun_reset");
    repeat (2) @(posedge clk);
    check(exp_q.size(), 32'h0);
    print_verdict();
  end
endmodule // testbench

// >>> verilog/pmsr_pkg.sv
// Constants, carriers and state layout for the management register subset
// Notes on behaviour
// - Status bits 14:13 read 1, or 0 while the ten-megabit-only strap is active.
// - Status bits 12:11 always read 1; read-only.
// - Status bit 15 and bits 10:7 always read zero; read-only.
// - Status bit 6 reads 0; station must send full preamble.
// - Status bit 5 reads 1 only after negotiation completes; resets to 0.
// - Status bit 4 shows a detected remote fault; resets to 0.
// - Status bit 3 constantly reads 1: negotiation capable.
// - Status bit 2 shows valid link, resets to 0, latches low.
// - Status bit 1 flags jabber, latches high, resets 0, only at ten megabit.
// - Status bit 0 constantly reads 1: extended registers present.
// - Registers 2 and 3 return fixed upper and lower identifier halves.
// - Advertisement bits 15 and 14 always read 0.
// - Advertisement bit 13 writable, resets 0, advertises remote fault.
// - Advertisement bits 12:5 writable ability field, reset 00101111.
// - Advertisement bits 4:0 read-only selector holding 00001.
// - Latch-low bits hold 0, latch-high bits hold 1, once condition occurs.
package pmsr_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_BASIC_STATUS = 6'h01;
  localparam logic [5:0] IDX_IDENTIFIER_UPPER = 6'h02;
  localparam logic [5:0] IDX_IDENTIFIER_LOWER = 6'h03;
  localparam logic [5:0] IDX_NEGOTIATION_ADVERTISEMENT = 6'h04;

  // Status field positions
  localparam int ST_ABL_100FD = 14;
  localparam int ST_ABL_100HD = 13;
  localparam int ST_NO_PREAMBLE = 6;
  localparam int ST_AN_DONE = 5;
  localparam int ST_RFAULT = 4;
  localparam int ST_AN_ABLE = 3;
  localparam int ST_LINK = 2;
  localparam int ST_JABBER = 1;
  localparam int ST_EXT = 0;
  localparam logic [1:0] ST_ABL_10_BOTH = 2'h3;

  // Advertisement layout and reset
  localparam int ADV_RFAULT = 13;
  localparam int ADV_TECH_LSB = 5;
  localparam int ADV_TECH_MSB = 12;
  localparam logic [7:0] ADV_TECH_RST = 8'h2f;
  localparam logic [4:0] ADV_SELECTOR = 5'h01;
  localparam logic [15:0] ADV_RST = {3'h0, ADV_TECH_RST, ADV_SELECTOR};

  // Synchroniser lanes
  localparam int SY_LINK = 0;
  localparam int SY_JAB = 1;
  localparam int SY_RF = 2;
  localparam int SY_AN = 3;
  localparam int SY_10M = 4;
  localparam int SY_STRAP = 5;
  localparam int SY_W = 6;

  typedef enum logic [2:0] {
    PMSR_SEL_NONE = 3'b000,
    PMSR_SEL_STATUS = 3'b001,
    PMSR_SEL_IDU = 3'b010,
    PMSR_SEL_IDL = 3'b011,
    PMSR_SEL_ADV = 3'b100
  } pmsr_sel_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } pmsr_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } pmsr_apb_rsp_t;

  typedef struct packed {
    logic link_up;
    logic jabber;
    logic remote_fault;
    logic an_complete;
    logic at_10m;
  } pmsr_phy_line_t;

  typedef struct packed {
    logic [SY_W-1:0] sync1;
    logic [SY_W-1:0] sync2;
    logic link_latch_low_mark;
    logic jabber_latch_high_mark;
    logic [15:0] adv;
    pmsr_sel_t sel;
    pmsr_apb_rsp_t rsp;
  } pmsr_state_t;

  localparam pmsr_state_t ST_RESET = '{
    sync1: '0,
    sync2: '0,
    link_latch_low_mark: 1'b0,
    jabber_latch_high_mark: 1'b0,
    adv: ADV_RST,
    sel: PMSR_SEL_NONE,
    rsp: '0
  };

endpackage

// >>> verilog/pmsr_regs.sv
// Management status, identifier and advertisement registers behind an APB slave
`timescale 1ns/100ps
module pmsr_regs #(
  parameter logic [15:0] IDENT_UPPER = 16'h5a5a, // Arbitrary value
  parameter logic [15:0] IDENT_LOWER = 16'hc3c3 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire pmsr_pkg::pmsr_apb_req_t apb_req,
  output pmsr_pkg::pmsr_apb_rsp_t apb_rsp,
  // Line conditions and strap
  input wire pmsr_pkg::pmsr_phy_line_t phy_line,
  input wire logic ten_mbps_only_strap,
  // Page offered to the negotiation engine
  output logic [15:0] adv_page
);

  pmsr_pkg::pmsr_state_t st_q;
  pmsr_pkg::pmsr_state_t st_d;
  pmsr_pkg::pmsr_sel_t sel;
  logic setup;
  logic done;
  logic clr;
  logic live_link;
  logic live_jab;

  function automatic pmsr_pkg::pmsr_sel_t reg_sel(input logic [pmsr_pkg::ADDR_W-1:0] a);
    pmsr_pkg::pmsr_sel_t s;
    s = pmsr_pkg::PMSR_SEL_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[pmsr_pkg::ADDR_W-1:2])
        pmsr_pkg::IDX_BASIC_STATUS: s = pmsr_pkg::PMSR_SEL_STATUS;
        pmsr_pkg::IDX_IDENTIFIER_UPPER: s = pmsr_pkg::PMSR_SEL_IDU;
        pmsr_pkg::IDX_IDENTIFIER_LOWER: s = pmsr_pkg::PMSR_SEL_IDL;
        pmsr_pkg::IDX_NEGOTIATION_ADVERTISEMENT: s = pmsr_pkg::PMSR_SEL_ADV;
        default: s = pmsr_pkg::PMSR_SEL_NONE;
      endcase
    end
    return s;
  endfunction

  function automatic logic [15:0] status_word(
    input logic strap,
    input logic an_done,
    input logic rfault,
    input logic link,
    input logic jab
  );
    logic [15:0] w;
    w = 16'h0000;
    w[pmsr_pkg::ST_ABL_100FD] = ~strap;
    w[pmsr_pkg::ST_ABL_100HD] = ~strap;
    w[12:11] = pmsr_pkg::ST_ABL_10_BOTH;
    w[pmsr_pkg::ST_AN_DONE] = an_done;
    w[pmsr_pkg::ST_RFAULT] = rfault;
    w[pmsr_pkg::ST_AN_ABLE] = 1'b1;
    w[pmsr_pkg::ST_LINK] = link;
    w[pmsr_pkg::ST_JABBER] = jab;
    w[pmsr_pkg::ST_EXT] = 1'b1;
    return w;
  endfunction

  always_comb begin
    st_d = st_q;
    sel = reg_sel(apb_req.paddr);
    setup = apb_req.psel & ~apb_req.penable;
    done = apb_req.psel & apb_req.penable & st_q.rsp.pready;
    // Strap and line conditions come from outside the clock domain
    st_d.sync1[pmsr_pkg::SY_LINK] = phy_line.link_up;
    st_d.sync1[pmsr_pkg::SY_JAB] = phy_line.jabber;
    st_d.sync1[pmsr_pkg::SY_RF] = phy_line.remote_fault;
    st_d.sync1[pmsr_pkg::SY_AN] = phy_line.an_complete;
    st_d.sync1[pmsr_pkg::SY_10M] = phy_line.at_10m;
    st_d.sync1[pmsr_pkg::SY_STRAP] = ten_mbps_only_strap;
    st_d.sync2 = st_q.sync1;
    live_link = st_q.sync2[pmsr_pkg::SY_LINK];
    // Jabber only counts while running at ten megabit
    live_jab = st_q.sync2[pmsr_pkg::SY_JAB] & st_q.sync2[pmsr_pkg::SY_10M];
    clr = done & ~apb_req.pwrite & (st_q.sel == pmsr_pkg::PMSR_SEL_STATUS);
    // Release on read reloads the live level, so a drop in the clearing cycle stays seen
    if (clr) begin
      st_d.link_latch_low_mark = live_link;
      st_d.jabber_latch_high_mark = live_jab;
    end else begin
      st_d.link_latch_low_mark = st_q.link_latch_low_mark & live_link;
      st_d.jabber_latch_high_mark = st_q.jabber_latch_high_mark | live_jab;
    end
    // Only the writable fields move; the rest of the page keeps its constants
    if (done && apb_req.pwrite && st_q.sel == pmsr_pkg::PMSR_SEL_ADV) begin
      st_d.adv[pmsr_pkg::ADV_RFAULT] = apb_req.pwdata[pmsr_pkg::ADV_RFAULT];
      st_d.adv[pmsr_pkg::ADV_TECH_MSB:pmsr_pkg::ADV_TECH_LSB] =
        apb_req.pwdata[pmsr_pkg::ADV_TECH_MSB:pmsr_pkg::ADV_TECH_LSB];
    end
    // Zero wait: answer is ready in the first access cycle
    st_d.rsp.pready = setup & ~st_q.rsp.pready;
    if (setup) begin
      st_d.sel = sel;
      st_d.rsp.pslverr = (sel == pmsr_pkg::PMSR_SEL_NONE);
      // Snapshot takes the latch next-state so an event at this edge is shown
      case (sel)
        pmsr_pkg::PMSR_SEL_STATUS: st_d.rsp.prdata = {16'h0000, status_word(
          st_q.sync2[pmsr_pkg::SY_STRAP], st_q.sync2[pmsr_pkg::SY_AN],
          st_q.sync2[pmsr_pkg::SY_RF], st_d.link_latch_low_mark,
          st_d.jabber_latch_high_mark)};
        pmsr_pkg::PMSR_SEL_IDU: st_d.rsp.prdata = {16'h0000, IDENT_UPPER};
        pmsr_pkg::PMSR_SEL_IDL: st_d.rsp.prdata = {16'h0000, IDENT_LOWER};
        pmsr_pkg::PMSR_SEL_ADV: st_d.rsp.prdata = {16'h0000, st_q.adv};
        default: st_d.rsp.prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= pmsr_pkg::ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign apb_rsp = st_q.rsp;
  assign adv_page = st_q.adv;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence

  sequence s_access_done;
    apb_req.psel && apb_req.penable && apb_rsp.pready;
  endsequence

  sequence s_status_answer;
    apb_rsp.pready && st_q.sel == pmsr_pkg::PMSR_SEL_STATUS;
  endsequence

  sequence s_adv_answer;
    apb_rsp.pready && st_q.sel == pmsr_pkg::PMSR_SEL_ADV;
  endsequence

  property p_answer_timing;
    s_setup |=> apb_rsp.pready ##1 !apb_rsp.pready;
  endproperty
  a_answer_timing: assert property (p_answer_timing)
    else $error("pready not a single cycle after setup");

  property p_unmapped_error;
    apb_rsp.pready |-> apb_rsp.pslverr == (st_q.sel == pmsr_pkg::PMSR_SEL_NONE);
  endproperty
  a_unmapped_error: assert property (p_unmapped_error)
    else $error("pslverr does not match address decode");

  property p_ability_100;
    s_status_answer |-> apb_rsp.prdata[14:13] == {2{!$past(st_q.sync2[pmsr_pkg::SY_STRAP])}};
  endproperty
  a_ability_100: assert property (p_ability_100)
    else $error("100 Mbps ability bits disagree with strap");

  property p_ability_10;
    s_status_answer |-> apb_rsp.prdata[12:11] == pmsr_pkg::ST_ABL_10_BOTH;
  endproperty
  a_ability_10: assert property (p_ability_10)
    else $error("10 Mbps ability bits not set");

  property p_status_reserved;
    s_status_answer |-> apb_rsp.prdata[15] == 1'b0 && apb_rsp.prdata[10:7] == 4'h0
      && apb_rsp.prdata[31:16] == 16'h0000;
  endproperty
  a_status_reserved: assert property (p_status_reserved)
    else $error("Reserved status bits not zero");

  property p_no_preamble;
    s_status_answer |-> apb_rsp.prdata[pmsr_pkg::ST_NO_PREAMBLE] == 1'b0;
  endproperty
  a_no_preamble: assert property (p_no_preamble)
    else $error("Preamble suppression bit set");

  property p_an_done;
    s_status_answer |-> apb_rsp.prdata[pmsr_pkg::ST_AN_DONE] == $past(st_q.sync2[pmsr_pkg::SY_AN]);
  endproperty
  a_an_done: assert property (p_an_done)
    else $error("Negotiation done bit does not follow engine");

  property p_rfault;
    s_status_answer |-> apb_rsp.prdata[pmsr_pkg::ST_RFAULT] == $past(st_q.sync2[pmsr_pkg::SY_RF]);
  endproperty
  a_rfault: assert property (p_rfault)
    else $error("Remote fault bit does not follow condition");

  property p_an_able;
    s_status_answer |-> apb_rsp.prdata[pmsr_pkg::ST_AN_ABLE] == 1'b1;
  endproperty
  a_an_able: assert property (p_an_able)
    else $error("Negotiation ability bit clear");

  // Once low, only a completed status read may lift it again
  property p_link_hold_low;
    (!live_link || !st_q.link_latch_low_mark) && !clr |=> !st_q.link_latch_low_mark;
  endproperty
  a_link_hold_low: assert property (p_link_hold_low)
    else $error("Link bit did not latch low");

  property p_jabber_speed;
    !st_q.sync2[pmsr_pkg::SY_10M] && !st_q.jabber_latch_high_mark && !clr
      |=> !st_q.jabber_latch_high_mark;
  endproperty
  a_jabber_speed: assert property (p_jabber_speed)
    else $error("Jabber latched outside ten megabit operation");

  property p_ext;
    s_status_answer |-> apb_rsp.prdata[pmsr_pkg::ST_EXT] == 1'b1;
  endproperty
  a_ext: assert property (p_ext)
    else $error("Extended capability bit clear");

  property p_ident;
    apb_rsp.pready && (st_q.sel == pmsr_pkg::PMSR_SEL_IDU || st_q.sel == pmsr_pkg::PMSR_SEL_IDL)
      |-> apb_rsp.prdata == {16'h0000, (st_q.sel == pmsr_pkg::PMSR_SEL_IDU) ? IDENT_UPPER
      : IDENT_LOWER};
  endproperty
  a_ident: assert property (p_ident)
    else $error("Identifier register returned wrong half");

  property p_adv_top_zero;
    s_adv_answer |-> apb_rsp.prdata[15:14] == 2'h0;
  endproperty
  a_adv_top_zero: assert property (p_adv_top_zero)
    else $error("Next page or reserved advertisement bit set");

  property p_adv_rfault_write;
    s_access_done ##0 (apb_req.pwrite && st_q.sel == pmsr_pkg::PMSR_SEL_ADV)
      |=> adv_page[pmsr_pkg::ADV_RFAULT] == $past(apb_req.pwdata[pmsr_pkg::ADV_RFAULT]);
  endproperty
  a_adv_rfault_write: assert property (p_adv_rfault_write)
    else $error("Advertised remote fault not written");

  property p_adv_tech_write;
    s_access_done ##0 (apb_req.pwrite && st_q.sel == pmsr_pkg::PMSR_SEL_ADV)
      |=> adv_page[12:5] == $past(apb_req.pwdata[12:5]);
  endproperty
  a_adv_tech_write: assert property (p_adv_tech_write)
    else $error("Technology ability field not written");

  property p_adv_selector;
    s_adv_answer |-> apb_rsp.prdata[4:0] == pmsr_pkg::ADV_SELECTOR && adv_page[4:0]
      == pmsr_pkg::ADV_SELECTOR;
  endproperty
  a_adv_selector: assert property (p_adv_selector)
    else $error("Selector field altered");

  property p_jabber_hold_high;
    live_jab || (st_q.jabber_latch_high_mark && !clr) |=> st_q.jabber_latch_high_mark;
  endproperty
  a_jabber_hold_high: assert property (p_jabber_hold_high)
    else $error("Jabber bit did not latch high");

  property p_read_release;
    clr |=> st_q.link_latch_low_mark == $past(live_link)
      && st_q.jabber_latch_high_mark == $past(live_jab);
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("Latched bits not released by status read");

  property p_ro_write_ignored;
    s_access_done ##0 (apb_req.pwrite && st_q.sel != pmsr_pkg::PMSR_SEL_ADV)
      |=> $stable(adv_page) ##1 $stable(adv_page[15:14]);
  endproperty
  a_ro_write_ignored: assert property (p_ro_write_ignored)
    else $error("Write to read-only register changed state");

  property p_adv_ro_bits;
    adv_page[15:14] == 2'h0 && adv_page[4:0] == pmsr_pkg::ADV_SELECTOR;
  endproperty
  a_adv_ro_bits: assert property (p_adv_ro_bits)
    else $error("Read-only advertisement bits altered");

  // A page change without a completed write would reach the link partner unasked
  property p_adv_hold;
    !(apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
      && st_q.sel == pmsr_pkg::PMSR_SEL_ADV) |=> $stable(adv_page);
  endproperty
  a_adv_hold: assert property (p_adv_hold)
    else $error("Advertisement changed without a write");

  property p_unmapped_data;
    apb_rsp.pready && apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0000_0000;
  endproperty
  a_unmapped_data: assert property (p_unmapped_data)
    else $error("Refused access returned data");

  property p_link_rise_on_read;
    $rose(st_q.link_latch_low_mark) |-> $past(clr);
  endproperty
  a_link_rise_on_read: assert property (p_link_rise_on_read)
    else $error("Link bit rose without a status read");

  property p_jabber_fall_on_read;
    $fell(st_q.jabber_latch_high_mark) |-> $past(clr);
  endproperty
  a_jabber_fall_on_read: assert property (p_jabber_fall_on_read)
    else $error("Jabber bit fell without a status read");

  // A write, even to status, must not act as a release
  property p_write_no_release;
    s_access_done ##0 apb_req.pwrite |=> st_q.jabber_latch_high_mark
      == ($past(st_q.jabber_latch_high_mark) || $past(live_jab));
  endproperty
  a_write_no_release: assert property (p_write_no_release)
    else $error("Write released the jabber latch");

endmodule // pmsr_regs
